// File: core/i2cs_line_if.sv
// Purpose: Synchronised bus line levels and events
// Assumes: All signals on clock_i
// Notes:   Events are one-cycle pulses
`timescale 1ns/10ps
interface i2cs_line_if;
   logic scl_level;
   logic sda_level;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;

   modport producer (output scl_level, sda_level, scl_rise, scl_fall, start, stop);
   modport consumer (input scl_level, sda_level, scl_rise, scl_fall, start, stop);
endinterface : i2cs_line_if

// File: core/i2cs_line_sync.sv
// Purpose: Two-flop synchronisers and edge, START, STOP detection for SCL and SDA
// Assumes: Bus lines are asynchronous to clock_i
// Notes:   Index 0 is SCL, index 1 is SDA
`timescale 1ns/10ps
module i2cs_line_sync (
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   i2cs_line_if.producer   line
);
   i2cs_pkg::i2cs_sync_s s_reg;
   i2cs_pkg::i2cs_sync_s s_next;

   always_comb
   begin
      s_next      = s_reg;
      s_next.meta = {sda_i, scl_i};
      s_next.stab = s_reg.meta;
      s_next.prev = s_reg.stab;
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         s_reg <= '{meta: 2'h3, stab: 2'h3, prev: 2'h3};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // Only the stable stage and its delayed copy feed the decoders
   assign line.scl_level = s_reg.stab[0];
   assign line.sda_level = s_reg.stab[1];
   assign line.scl_rise  = s_reg.stab[0] & ~s_reg.prev[0];
   assign line.scl_fall  = ~s_reg.stab[0] & s_reg.prev[0];
   assign line.start     = s_reg.stab[0] & s_reg.prev[0] & ~s_reg.stab[1] & s_reg.prev[1];
   assign line.stop      = s_reg.stab[0] & s_reg.prev[0] & s_reg.stab[1] & ~s_reg.prev[1];
endmodule : i2cs_line_sync

// File: core/i2cs_pkg.sv
// Purpose: Types shared by the I2C slave modules
// Assumes: Offsets and fields come from i2cs_regs.svh
// Notes:   No constants here, only types
package i2cs_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_STRETCH,
      ST_RX,
      ST_RX_ACK,
      ST_TX,
      ST_TX_ACK,
      ST_WAIT_STOP
   } i2cs_state_e;

   typedef enum logic [1:0] {
      SEL_CTRL,
      SEL_DATA,
      SEL_OWN,
      SEL_NONE
   } i2cs_sel_e;

   typedef struct packed {
      i2cs_state_e st;
      logic [3:0]  cnt;
      logic [7:0]  sr;
      logic [7:0]  data;
      logic [7:0]  own;
      logic        busy;
      logic        match;
      logic        dir;
      logic        txsel;
      logic        ack_send;
      logic        wake;
      logic        ack_rcv;
      logic        done;
      logic        sda_oe_n;
      logic        scl_oe_n;
      logic        pin_lvl;
      logic        irq;
      logic        aw_rdy;
      logic        aw_got;
      i2cs_sel_e   aw_sel;
      logic        w_rdy;
      logic        w_got;
      logic [7:0]  w_data;
      logic        w_lane0;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        ar_rdy;
      logic        rvalid;
      logic [7:0]  rdata;
      logic [1:0]  rresp;
   } i2cs_core_s;

   typedef struct packed {
      logic [1:0] meta;
      logic [1:0] stab;
      logic [1:0] prev;
   } i2cs_sync_s;

endpackage : i2cs_pkg

// File: core/i2cs_regs.svh
// Purpose: Register offsets, field positions and reset values of the I2C slave
// Assumes: 32-bit AXI4-Lite words, 8-bit registers in the low byte lane
// Notes:   Definitions only
`ifndef I2CS_REGS_SVH
`define I2CS_REGS_SVH

`define I2CS_OFF_CTRL     8'h00
`define I2CS_OFF_DATA     8'h04
`define I2CS_OFF_OWN      8'h08

`define I2CS_CTRL_RST     8'h81
`define I2CS_BIT_DONE     7
`define I2CS_BIT_MATCH    6
`define I2CS_BIT_BUSY     5
`define I2CS_BIT_TXSEL    4
`define I2CS_BIT_ACKSEND  3
`define I2CS_BIT_DIR      2
`define I2CS_BIT_WAKE     1
`define I2CS_BIT_ACKRCV   0

`define I2CS_RESP_OKAY    2'b00
`define I2CS_RESP_SLVERR  2'b10

`define I2CS_BYTE_BITS    4'h8
`define I2CS_LAST_RISE    4'h7

`endif

// File: core/i2cs_slave.sv
// Purpose: I2C slave protocol engine with AXI4-Lite register access
// Assumes: Open-drain pins resolved outside; bus lines asynchronous to clock_i
// Notes:   SCL is held low after every address match and every acknowledged byte until firmware acts
//
// Contract
// - START is SDA falling while SCL high; set busy
// - Shift seven-bit address after START, compare own
// - Address match sets match flag, raises request
// - Eighth bit after START becomes direction flag
// - Acknowledge matched address low in ninth bit
// - Hold SCL low until data write or read
// - Bytes are eight bits, MSB first
// - Receiver acknowledges low after each eighth bit; data bytes are acknowledged low only while ack_send is 0
// - Transmitter releases SDA when master does not acknowledge
// - Receiver drives ack_to_send on ninth clock
// - Transmitter uses received ack to continue or stop
// - Bytes pass through shared data register
// - Byte flag clears while moving, sets when done
// - STOP clears the busy flag
// - Own address taken from address register bits 7..1
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "i2cs_regs.svh"
module i2cs_slave #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clock_i,
   input  wire logic              rst_i,
   input  wire logic              scl_i,
   output logic                   scl_o,
   output logic                   scl_oe_n_o,
   input  wire logic              sda_i,
   output logic                   sda_o,
   output logic                   sda_oe_n_o,
   output logic                   irq_o,
   input  wire logic [ADDR_W-1:0] awaddr_i,
   input  wire logic              awvalid_i,
   output logic                   awready_o,
   input  wire logic [31:0]       wdata_i,
   input  wire logic [3:0]        wstrb_i,
   input  wire logic              wvalid_i,
   output logic                   wready_o,
   output logic [1:0]             bresp_o,
   output logic                   bvalid_o,
   input  wire logic              bready_i,
   input  wire logic [ADDR_W-1:0] araddr_i,
   input  wire logic              arvalid_i,
   output logic                   arready_o,
   output logic [31:0]            rdata_o,
   output logic [1:0]             rresp_o,
   output logic                   rvalid_o,
   input  wire logic              rready_i
);
   if (ADDR_W < 4 || ADDR_W > 32)
   begin : g_chk
      $error("ADDR_W must lie between 4 and 32");
   end

   i2cs_pkg::i2cs_core_s r_reg;
   i2cs_pkg::i2cs_core_s r_next;
   logic [7:0]           rx_byte;

   i2cs_line_if line ();

   i2cs_line_sync u_sync (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .scl_i   (scl_i),
      .sda_i   (sda_i),
      .line    (line.producer)
   );

   function automatic i2cs_pkg::i2cs_sel_e reg_sel(input logic [ADDR_W-1:0] a);
      if (a == ADDR_W'(`I2CS_OFF_CTRL))
         return i2cs_pkg::SEL_CTRL;
      else if (a == ADDR_W'(`I2CS_OFF_DATA))
         return i2cs_pkg::SEL_DATA;
      else if (a == ADDR_W'(`I2CS_OFF_OWN))
         return i2cs_pkg::SEL_OWN;
      else
         return i2cs_pkg::SEL_NONE;
   endfunction : reg_sel

   assign rx_byte = {r_reg.sr[6:0], line.sda_level};

   always_comb
   begin
      logic                wr_go;
      logic                wr_data;
      logic                rd_data;
      logic [7:0]          rd_ctrl;
      i2cs_pkg::i2cs_sel_e rsel;
      wr_go   = 1'b0;
      wr_data = 1'b0;
      rd_data = 1'b0;
      rd_ctrl = 8'h00;
      rsel    = reg_sel(araddr_i);
      r_next  = r_reg;
      r_next.irq     = 1'b0;
      r_next.pin_lvl = 1'b0;

      // Write channels are taken independently, answered once both are in
      if (awvalid_i && r_reg.aw_rdy)
      begin
         r_next.aw_got = 1'b1;
         r_next.aw_sel = reg_sel(awaddr_i);
      end
      if (wvalid_i && r_reg.w_rdy)
      begin
         r_next.w_got   = 1'b1;
         r_next.w_data  = wdata_i[7:0];
         r_next.w_lane0 = wstrb_i[0];
      end
      if (r_reg.bvalid && bready_i)
         r_next.bvalid = 1'b0;
      if (r_next.aw_got && r_next.w_got && !r_next.bvalid)
      begin
         wr_go         = 1'b1;
         r_next.aw_got = 1'b0;
         r_next.w_got  = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp  = (r_next.aw_sel == i2cs_pkg::SEL_NONE) ?
                         `I2CS_RESP_SLVERR : `I2CS_RESP_OKAY;
      end
      if (wr_go && r_next.w_lane0)
      begin
         case (r_next.aw_sel)
            i2cs_pkg::SEL_CTRL:
            begin
               r_next.txsel    = r_next.w_data[`I2CS_BIT_TXSEL];
               r_next.ack_send = r_next.w_data[`I2CS_BIT_ACKSEND];
               r_next.wake     = r_next.w_data[`I2CS_BIT_WAKE];
            end
            i2cs_pkg::SEL_DATA:
            begin
               r_next.data = r_next.w_data;
               wr_data     = 1'b1;
            end
            i2cs_pkg::SEL_OWN:
               r_next.own = r_next.w_data;
            default:
               r_next.own = r_reg.own;
         endcase
      end
      r_next.aw_rdy = !r_next.aw_got && !r_next.bvalid;
      r_next.w_rdy  = !r_next.w_got && !r_next.bvalid;

      // Read channel
      rd_ctrl[`I2CS_BIT_DONE]    = r_reg.done;
      rd_ctrl[`I2CS_BIT_MATCH]   = r_reg.match;
      rd_ctrl[`I2CS_BIT_BUSY]    = r_reg.busy;
      rd_ctrl[`I2CS_BIT_TXSEL]   = r_reg.txsel;
      rd_ctrl[`I2CS_BIT_ACKSEND] = r_reg.ack_send;
      rd_ctrl[`I2CS_BIT_DIR]     = r_reg.dir;
      rd_ctrl[`I2CS_BIT_WAKE]    = r_reg.wake;
      rd_ctrl[`I2CS_BIT_ACKRCV]  = r_reg.ack_rcv;
      if (r_reg.rvalid && rready_i)
         r_next.rvalid = 1'b0;
      if (arvalid_i && r_reg.ar_rdy)
      begin
         r_next.rvalid = 1'b1;
         r_next.rresp  = `I2CS_RESP_OKAY;
         case (rsel)
            i2cs_pkg::SEL_CTRL:
               r_next.rdata = rd_ctrl;
            i2cs_pkg::SEL_DATA:
            begin
               r_next.rdata = r_reg.data;
               rd_data      = 1'b1;
            end
            i2cs_pkg::SEL_OWN:
               r_next.rdata = r_reg.own;
            default:
            begin
               r_next.rdata = 8'h00;
               r_next.rresp = `I2CS_RESP_SLVERR;
            end
         endcase
      end
      r_next.ar_rdy = !r_next.rvalid;

      // Protocol engine; SDA only moves while SCL is low, so no START is made
      case (r_reg.st)
         i2cs_pkg::ST_ADDR:
         begin
            if (line.scl_rise)
            begin
               r_next.sr  = rx_byte;
               r_next.cnt = r_reg.cnt + 4'h1;
               if (r_reg.cnt == `I2CS_LAST_RISE)
               begin
                  // Bit 0 of the own address takes no part in matching
                  if (r_reg.sr[6:0] == r_reg.own[7:1])
                  begin
                     r_next.match = 1'b1;
                     r_next.irq   = 1'b1;
                     r_next.dir   = line.sda_level;
                  end
               end
            end
            else if (line.scl_fall && r_reg.cnt == `I2CS_BYTE_BITS)
            begin
               if (r_reg.match)
               begin
                  r_next.sda_oe_n = 1'b0;
                  r_next.st       = i2cs_pkg::ST_ADDR_ACK;
               end
               else
                  r_next.st = i2cs_pkg::ST_WAIT_STOP;
            end
         end
         i2cs_pkg::ST_ADDR_ACK:
         begin
            if (line.scl_fall)
            begin
               r_next.sda_oe_n = 1'b1;
               r_next.scl_oe_n = 1'b0;
               r_next.st       = i2cs_pkg::ST_STRETCH;
            end
         end
         i2cs_pkg::ST_STRETCH:
         begin
            // Firmware picks the direction from the direction flag
            if ((r_reg.txsel && wr_data) || (!r_reg.txsel && rd_data))
            begin
               r_next.scl_oe_n = 1'b1;
               r_next.cnt      = 4'h0;
               r_next.done     = 1'b0;
               if (r_reg.txsel)
               begin
                  r_next.sr       = r_next.data;
                  r_next.sda_oe_n = r_next.data[7];
                  r_next.st       = i2cs_pkg::ST_TX;
               end
               else
                  r_next.st = i2cs_pkg::ST_RX;
            end
         end
         i2cs_pkg::ST_RX:
         begin
            if (line.scl_rise)
            begin
               r_next.sr  = rx_byte;
               r_next.cnt = r_reg.cnt + 4'h1;
               if (r_reg.cnt == `I2CS_LAST_RISE)
               begin
                  r_next.data  = rx_byte;
                  r_next.done  = 1'b1;
                  r_next.irq   = 1'b1;
                  r_next.match = 1'b0;
               end
            end
            else if (line.scl_fall && r_reg.cnt == `I2CS_BYTE_BITS)
            begin
               r_next.sda_oe_n = r_reg.ack_send;
               r_next.st       = i2cs_pkg::ST_RX_ACK;
            end
         end
         i2cs_pkg::ST_RX_ACK:
         begin
            if (line.scl_fall)
            begin
               r_next.sda_oe_n = 1'b1;
               // A withheld acknowledge takes no further byte
               if (!r_reg.ack_send)
               begin
                  r_next.scl_oe_n = 1'b0;
                  r_next.st       = i2cs_pkg::ST_STRETCH;
               end
               else
                  r_next.st = i2cs_pkg::ST_WAIT_STOP;
            end
         end
         i2cs_pkg::ST_TX:
         begin
            if (line.scl_rise)
            begin
               r_next.cnt = r_reg.cnt + 4'h1;
               if (r_reg.cnt == `I2CS_LAST_RISE)
               begin
                  r_next.done  = 1'b1;
                  r_next.irq   = 1'b1;
                  r_next.match = 1'b0;
               end
            end
            else if (line.scl_fall)
            begin
               if (r_reg.cnt == `I2CS_BYTE_BITS)
               begin
                  r_next.sda_oe_n = 1'b1;
                  r_next.st       = i2cs_pkg::ST_TX_ACK;
               end
               else
               begin
                  r_next.sr       = {r_reg.sr[6:0], 1'b0};
                  r_next.sda_oe_n = r_reg.sr[6];
               end
            end
         end
         i2cs_pkg::ST_TX_ACK:
         begin
            if (line.scl_rise)
               r_next.ack_rcv = line.sda_level;
            else if (line.scl_fall)
            begin
               if (!r_reg.ack_rcv)
               begin
                  r_next.scl_oe_n = 1'b0;
                  r_next.st       = i2cs_pkg::ST_STRETCH;
               end
               else
                  r_next.st = i2cs_pkg::ST_WAIT_STOP;
            end
         end
         default:
            r_next.st = r_reg.st;
      endcase

      // Bus conditions override any byte in flight
      if (line.start)
      begin
         r_next.busy     = 1'b1;
         r_next.st       = i2cs_pkg::ST_ADDR;
         r_next.cnt      = 4'h0;
         r_next.match    = 1'b0;
         r_next.sda_oe_n = 1'b1;
         r_next.scl_oe_n = 1'b1;
      end
      else if (line.stop)
      begin
         r_next.busy     = 1'b0;
         r_next.st       = i2cs_pkg::ST_IDLE;
         r_next.match    = 1'b0;
         r_next.sda_oe_n = 1'b1;
         r_next.scl_oe_n = 1'b1;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         r_reg          <= '0;
         r_reg.st       <= i2cs_pkg::ST_IDLE;
         r_reg.done     <= 1'(`I2CS_CTRL_RST >> `I2CS_BIT_DONE);
         r_reg.ack_rcv  <= 1'(`I2CS_CTRL_RST >> `I2CS_BIT_ACKRCV);
         r_reg.sda_oe_n <= 1'b1;
         r_reg.scl_oe_n <= 1'b1;
         r_reg.aw_rdy   <= 1'b1;
         r_reg.w_rdy    <= 1'b1;
         r_reg.ar_rdy   <= 1'b1;
         r_reg.aw_sel   <= i2cs_pkg::SEL_NONE;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign scl_o      = r_reg.pin_lvl;
   assign sda_o      = r_reg.pin_lvl;
   assign scl_oe_n_o = r_reg.scl_oe_n;
   assign sda_oe_n_o = r_reg.sda_oe_n;
   assign irq_o      = r_reg.irq;
   assign awready_o  = r_reg.aw_rdy;
   assign wready_o   = r_reg.w_rdy;
   assign bvalid_o   = r_reg.bvalid;
   assign bresp_o    = r_reg.bresp;
   assign arready_o  = r_reg.ar_rdy;
   assign rvalid_o   = r_reg.rvalid;
   assign rresp_o    = r_reg.rresp;
   assign rdata_o    = {24'h000000, r_reg.rdata};

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   start_busy_a: assert property (line.start |=> r_reg.busy)
      else $error("START did not set busy");
   stop_busy_a: assert property (line.stop |=> !r_reg.busy && r_reg.st == i2cs_pkg::ST_IDLE)
      else $error("STOP did not free the bus");
   own_match_a: assert property ((r_reg.st == i2cs_pkg::ST_ADDR && line.scl_rise &&
      r_reg.cnt == 4'h7 && r_reg.sr[6:0] == r_reg.own[7:1] && !line.start) |=>
      r_reg.match && r_reg.irq)
      else $error("Address match not flagged");
   dir_capture_a: assert property ((r_reg.st == i2cs_pkg::ST_ADDR && line.scl_rise &&
      r_reg.cnt == 4'h7 && r_reg.sr[6:0] == r_reg.own[7:1]) |=>
      r_reg.dir == $past(line.sda_level))
      else $error("Direction bit not captured");
   addr_ack_a: assert property (r_reg.st == i2cs_pkg::ST_ADDR_ACK |-> !r_reg.sda_oe_n)
      else $error("Address acknowledge not driven");
   stretch_hold_a: assert property (r_reg.st == i2cs_pkg::ST_STRETCH |->
      !r_reg.scl_oe_n && r_reg.sda_oe_n)
      else $error("SCL not held during stretch");
   rx_ack_a: assert property ((r_reg.st == i2cs_pkg::ST_RX_ACK &&
      $past(r_reg.st) != i2cs_pkg::ST_RX_ACK) |-> r_reg.sda_oe_n == $past(r_reg.ack_send))
      else $error("Receive acknowledge level wrong");
   tx_msb_a: assert property ((r_reg.st == i2cs_pkg::ST_TX && line.scl_fall &&
      r_reg.cnt != 4'h8) |=> r_reg.sda_oe_n == $past(r_reg.sr[6]))
      else $error("Transmit bit order wrong");
   tx_nack_a: assert property ((r_reg.st == i2cs_pkg::ST_TX_ACK && line.scl_fall &&
      r_reg.ack_rcv) |=> r_reg.st == i2cs_pkg::ST_WAIT_STOP && r_reg.sda_oe_n)
      else $error("SDA not released after no acknowledge");
   rx_store_a: assert property ((r_reg.st == i2cs_pkg::ST_RX && line.scl_rise &&
      r_reg.cnt == 4'h7 && !line.start) |=> r_reg.data == $past(rx_byte) && r_reg.done)
      else $error("Received byte not stored");
   done_irq_a: assert property ($rose(r_reg.done) |-> r_reg.irq)
      else $error("Byte completion without request");

   match_seen_c: cover property (r_reg.st == i2cs_pkg::ST_ADDR_ACK);
   rx_byte_c: cover property (r_reg.st == i2cs_pkg::ST_RX_ACK ##1 r_reg.st == i2cs_pkg::ST_STRETCH);
   tx_byte_c: cover property (r_reg.st == i2cs_pkg::ST_TX_ACK);
   stop_seen_c: cover property (line.stop && r_reg.busy);
endmodule : i2cs_slave

// File: verif/i2cs_master_model.sv
// Purpose: Behavioural I2C bus master for the slave bench
// Assumes: Both lines pulled up; released reads 1
// Notes:   SCL stands still between frames
`timescale 1ns/10ps
module i2cs_master_model (
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   localparam realtime Q = 31.25;
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Waits out stretching; the bench watchdog ends a stuck slave
   task automatic pulse(output logic smp);
      scl_o = 1'b1;
      wait (scl_i === 1'b1);
      #Q;
      smp = sda_i;
      #Q;
      scl_o = 1'b0;
      #Q;
   endtask : pulse
   task automatic start_c();
      sda_o = 1'b1;
      scl_o = 1'b1;
      #(2*Q);
      sda_o = 1'b0;
      #(2*Q);
      scl_o = 1'b0;
      #Q;
   endtask : start_c
   task automatic stop_c();
      sda_o = 1'b0;
      #Q;
      scl_o = 1'b1;
      wait (scl_i === 1'b1);
      #(2*Q);
      sda_o = 1'b1;
      #(2*Q);
   endtask : stop_c
   task automatic xfer(input logic [7:0] tx, input logic ack_tx,
                       output logic [7:0] rx, output logic ack_rx);
      for (int i = 7; i >= 0; i--)
      begin
         sda_o = tx[i];
         #Q;
         pulse(rx[i]);
      end
      sda_o = ack_tx;
      #Q;
      pulse(ack_rx);
      sda_o = 1'b1;
   endtask : xfer
endmodule : i2cs_master_model

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the I2C slave
// Assumes: AXI4-Lite master and bus master model drive the slave
// Notes:   Read results are compared by a monitor from a queue
`timescale 1ns/10ps
`include "i2cs_regs.svh"
module tb_top;
   logic        clock_i, rst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
   logic [7:0]  awaddr_i, araddr_i, b1, b2, rx;
   logic [31:0] wdata_i, rdata_o;
   logic [3:0]  wstrb_i;
   logic        scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, irq_o, awready_o, wready_o;
   logic        bvalid_o, arready_o, rvalid_o, m_scl, m_sda, ak;
   logic [1:0]  bresp_o, rresp_o;
   logic [6:0]  own;
   logic [33:0] exp_q[$], msk_q[$];
   int          bad_count, check_count, irq_n;
   wire         scl_w = m_scl & (scl_oe_n_o | scl_o);
   wire         sda_w = m_sda & (sda_oe_n_o | sda_o);
   i2cs_slave DUT (.clock_i, .rst_i, .scl_i(scl_w), .scl_o, .scl_oe_n_o, .sda_i(sda_w),
      .sda_o, .sda_oe_n_o, .irq_o, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i,
      .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i,
      .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i);
   i2cs_master_model u_master (.scl_i(scl_w), .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda));
   always #5 clock_i = ~clock_i;
   function automatic logic [33:0] okv(input logic [7:0] v);
      return {`I2CS_RESP_OKAY, 24'h0, v};
   endfunction : okv
   function automatic logic [33:0] mk(input logic [7:0] m);
      return {2'h3, 24'h0, m};
   endfunction : mk
   task automatic check_val(input logic [33:0] seen, input logic [33:0] e);
      check_count++;
      if (seen !== e)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, e);
      end
   endtask : check_val
   task automatic expect_now(input logic [7:0] s, input logic [7:0] e);
      check_val({26'h0, s}, {26'h0, e});
   endtask : expect_now
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
      exp_q.push_back({r, 32'h0});
      msk_q.push_back({2'h3, 32'h0});
      @(posedge clock_i);
      awaddr_i <= a;
      wdata_i <= {24'h0, d};
      awvalid_i <= 1'b1;
      wvalid_i <= 1'b1;
      bready_i <= 1'b1;
      do
      begin
         @(posedge clock_i);
         if (awready_o === 1'b1)
            awvalid_i <= 1'b0;
         if (wready_o === 1'b1)
            wvalid_i <= 1'b0;
      end
      while (bvalid_o !== 1'b1);
      bready_i <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge clock_i);
      araddr_i <= a;
      arvalid_i <= 1'b1;
      rready_i <= 1'b1;
      do
      begin
         @(posedge clock_i);
         if (arready_o === 1'b1)
            arvalid_i <= 1'b0;
      end
      while (rvalid_o !== 1'b1);
      rready_i <= 1'b0;
   endtask : axi_rd
   task automatic wait_stretch();
      do
         @(posedge clock_i);
      while (scl_oe_n_o !== 1'b0);
   endtask : wait_stretch
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : final_report
   always @(posedge clock_i)
   begin : mon
      logic [33:0] e, m;
      if (irq_o === 1'b1)
         irq_n++;
      if ((bvalid_o === 1'b1 && bready_i) || (rvalid_o === 1'b1 && rready_i))
      begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         check_val((bvalid_o ? {bresp_o, 32'h0} : {rresp_o, rdata_o}) & m, e & m);
      end
   end
   initial
   begin
      #400000;
      bad_count++;
      final_report();
   end
   initial
   begin
      {clock_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
      {awaddr_i, araddr_i, wdata_i} = '0;
      wstrb_i = 4'hf;
      rst_i = 1'b1;
      repeat (8) @(posedge clock_i);
      rst_i <= 1'b0;
      void'($urandom(32'h6ea2));
      own = 7'($urandom_range(8'h77, 8'h08));
      b1 = 8'($urandom);
      b2 = 8'($urandom);
      repeat (3) @(posedge clock_i);
      axi_rd(`I2CS_OFF_CTRL, okv(`I2CS_CTRL_RST), mk(8'hff));
      axi_rd(8'h0c, {`I2CS_RESP_SLVERR, 32'h0}, '1);
      axi_wr(8'h0c, 8'hff, `I2CS_RESP_SLVERR);
      axi_wr(`I2CS_OFF_OWN, {own, 1'b1}, `I2CS_RESP_OKAY);
      axi_rd(`I2CS_OFF_OWN, okv({own, 1'b1}), mk(8'hff));
      // Lane 0 strobe off: write answered but ignored
      wstrb_i <= 4'h0;
      axi_wr(`I2CS_OFF_OWN, 8'h00, `I2CS_RESP_OKAY);
      wstrb_i <= 4'hf;
      axi_rd(`I2CS_OFF_OWN, okv({own, 1'b1}), mk(8'hff));
      // Master writes two bytes, the second refused
      u_master.start_c();
      axi_rd(`I2CS_OFF_CTRL, okv(8'h20), mk(8'h20));
      u_master.xfer({own, 1'b0}, 1'b1, rx, ak);
      expect_now({7'h0, ak}, 8'h00);
      fork
         u_master.xfer(b1, 1'b1, rx, ak);
         begin
            wait_stretch();
            axi_rd(`I2CS_OFF_CTRL, okv(8'h60), mk(8'h64));
            axi_rd(`I2CS_OFF_DATA, okv(8'h00), mk(8'h00));
         end
      join
      expect_now({7'h0, ak}, 8'h00);
      wait_stretch();
      axi_rd(`I2CS_OFF_CTRL, okv(8'h80), mk(8'hc0));
      axi_wr(`I2CS_OFF_CTRL, 8'h08, `I2CS_RESP_OKAY);
      axi_rd(`I2CS_OFF_DATA, okv(b1), mk(8'hff));
      u_master.xfer(b2, 1'b1, rx, ak);
      expect_now({7'h0, ak}, 8'h01);
      axi_rd(`I2CS_OFF_DATA, okv(b2), mk(8'hff));
      u_master.stop_c();
      axi_rd(`I2CS_OFF_CTRL, okv(8'h00), mk(8'h20));
      axi_wr(`I2CS_OFF_CTRL, 8'h02, `I2CS_RESP_OKAY);
      axi_rd(`I2CS_OFF_CTRL, okv(8'h02), mk(8'h1a));
      // Foreign address gets no acknowledge
      u_master.start_c();
      u_master.xfer({own ^ 7'h01, 1'b0}, 1'b1, rx, ak);
      expect_now({7'h0, ak}, 8'h01);
      axi_rd(`I2CS_OFF_CTRL, okv(8'h20), mk(8'h60));
      u_master.stop_c();
      // Master reads two bytes, refusing the second
      u_master.start_c();
      u_master.xfer({own, 1'b1}, 1'b1, rx, ak);
      expect_now({7'h0, ak}, 8'h00);
      fork
         u_master.xfer(8'hff, 1'b0, rx, ak);
         begin
            wait_stretch();
            axi_rd(`I2CS_OFF_CTRL, okv(8'h04), mk(8'h04));
            axi_wr(`I2CS_OFF_CTRL, 8'h10, `I2CS_RESP_OKAY);
            axi_wr(`I2CS_OFF_DATA, b1, `I2CS_RESP_OKAY);
         end
      join
      expect_now(rx, b1);
      fork
         u_master.xfer(8'hff, 1'b1, rx, ak);
         begin
            wait_stretch();
            axi_rd(`I2CS_OFF_CTRL, okv(8'h00), mk(8'h01));
            axi_wr(`I2CS_OFF_DATA, b2, `I2CS_RESP_OKAY);
         end
      join
      expect_now(rx, b2);
      repeat (10) @(posedge clock_i);
      expect_now({7'h0, sda_oe_n_o}, 8'h01);
      axi_rd(`I2CS_OFF_CTRL, okv(8'h01), mk(8'h01));
      u_master.stop_c();
      expect_now(8'(irq_n), 8'h06);
      final_report();
   end
endmodule : tb_top
